// >>> shared/cbc_pkg.sv
`default_nettype none
package cbc_pkg;
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int BOOST_DLY_MS = 30;
   localparam int BOOST_DLY_CYC = CLK_HZ / 1000 * BOOST_DLY_MS;
   localparam int BLINK_MS = 500;
   localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
   localparam int SEC_CYC = CLK_HZ;
   localparam int SEC_PER_H = 3600;
   localparam int TMR_LOWV_H = 4;
   localparam int TMR_H0 = 5;
   localparam int TMR_H1 = 8;
   localparam int TMR_H2 = 12;
   localparam int TMR_H3 = 20;
   // Register offsets
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_BOOST = 4'h1;
   localparam logic [3:0] ADR_SYSMIN = 4'h2;
   localparam logic [3:0] ADR_FAST_CHARGE_CURRENT_SETTING = 4'h3;
   localparam logic [3:0] ADR_IPT = 4'h4;
   localparam logic [3:0] ADR_VREG = 4'h5;
   localparam logic [3:0] ADR_TMR = 4'h6;
   localparam logic [3:0] ADR_STAT0 = 4'h8;
   localparam logic [3:0] ADR_STAT1 = 4'h9;
   // Control register fields
   localparam int CT_CHG = 0;
   localparam int CT_OTG = 1;
   localparam int CT_CLK = 2;
   localparam int CT_IND_OFF = 3;
   localparam int CT_RCHG = 4;
   localparam int CT_SWOFF = 5;
   localparam int CT_TERM = 6;
   // Boost register fields
   localparam int BO_LIM_LSB = 0;
   localparam int BO_VSEL_LSB = 3;
   // Timer register fields
   localparam int TM_SEL_LSB = 0;
   localparam int TM_PROF = 2;
   localparam int TM_EN = 3;
   localparam int TM_HALF = 4;
   // Reset values
   localparam logic [7:0] RST_CTRL = 8'h41;
   localparam logic [7:0] RST_BOOST = 8'h38;
   localparam logic [7:0] RST_SYSMIN = 8'h05;
   localparam logic [7:0] RST_FAST_CHARGE_CURRENT_SETTING = 8'h20;
   localparam logic [7:0] RST_IPT = 8'h31;
   localparam logic [7:0] RST_VREG = 8'h17;
   localparam logic [7:0] RST_TMR = 8'h1E;
   // Status codes
   localparam logic [2:0] SRC_BOOST = 3'h7;
   localparam logic [1:0] PH_OFF = 2'h0;
   localparam logic [1:0] PH_PRE = 2'h1;
   localparam logic [1:0] PH_FAST = 2'h2;
   localparam logic [1:0] PH_DONE = 2'h3;
   localparam logic [1:0] FLT_TIMER = 2'h3;

   typedef enum logic [2:0] {CS_IDLE, CS_PRE, CS_FAST, CS_DONE, CS_FAULT} cbc_chg_state_t;
   typedef enum logic [1:0] {BS_OFF, BS_WAIT, BS_ON} cbc_boost_state_t;

   typedef struct packed {
      logic ce_n;
      logic boost_pin;
      logic conv_on;
      logic bat_lowv_ok;
      logic bat_2v_ok;
      logic bat_3v_ok;
      logic bat_minsys_lo;
      logic bat_otg_ok;
      logic bat_depl_ok;
      logic bat_rchg0_ok;
      logic bat_rchg1_ok;
      logic vbus_sleep;
      logic sys_below_bat;
      logic iin_over;
      logic vin_under;
      logic ts_chg_ok;
      logic ts_boost_ok;
      logic fast_charge_current_setting_below_term;
      logic thermal_reg;
   } cbc_cmp_t;

   typedef struct packed {
      logic boost_run;
      logic step_up_clock_sel;
      logic [2:0] step_up_current_limit;
      logic [3:0] boost_voltage_sel;
      logic [2:0] min_system_voltage_sel;
      logic chg_run;
      logic [1:0] cur_mode;
      logic [6:0] fast_charge_current_setting;
      logic [3:0] pre_current;
      logic [5:0] charge_voltage;
      logic temp_profile_en;
      logic chg_reduce;
      logic battery_switch;
   } cbc_ctl_t;
endpackage
`default_nettype wire

// >>> src/cbc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module cbc_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // First stage feeds only the second stage
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end

   assign q = s2_r;
endmodule
`default_nettype wire

// >>> src/cbc_ctrl_fsm.sv
// Functional notes
// (RULE1) Boost starts only with good battery, low input, pin and bit set, 30 ms wait.
// (RULE2) Boost current limit field picks output limit, 000 is 500 mA, top 2.4 A.
// (RULE3) Boost clock select is 500 kHz or 1.5 MHz; locked while boost bit set.
// (RULE4) Input source code reads 111 while boosting.
// (RULE5) Boost voltage select field defaults to 5 V and is writable.
// (RULE6) Boost stops when battery drops below the boost battery threshold.
// (RULE7) Minimum system voltage field, default 3.5 V, drives system regulation.
// (RULE8) Minimum-system flag set while battery below minimum and rail regulated.
// (RULE9) Input over-current or under-voltage reduces charge current until clear.
// (RULE10) Input voltage and current regulation flags follow the active limit.
// (RULE11) Battery switch turns on when system below battery, off at depletion.
// (RULE12) Bit set and pin low runs a charge cycle without host help.
// (RULE13) Charge parameters reset to the documented default settings.
// (RULE14) New cycle needs converter, enables, nonzero current, no faults, switch allowed.
// (RULE15) Terminate on low current above recharge level, not in regulation.
// (RULE16) After done, battery below selected recharge level restarts charging.
// (RULE17) After done, toggling the enable pin or bit starts a new cycle.
// (RULE18) Indicator low while charging, high when done or off, blinks on fault.
// (RULE19) Phase code 00 off, 01 precharge, 10 fast, 11 done.
// (RULE20) Interrupt pulse on charge completion.
// (RULE21) Phase follows battery: short and precharge below 3 V, fast above; the code never goes back from fast to precharge.
// (RULE22) In regulation, termination held off and safety timer runs at half rate.
// (RULE23) Timer expiry sets fault code 11 and pulses the interrupt.
// (RULE24) Analog comparator results are synchronised and used on the internal clock.
// (RULE25) Boost and charging exclusive; boost forces charger idle.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cbc_ctrl_fsm
   import cbc_pkg::*;
#(
   parameter int BOOST_DLY_CYCLES = BOOST_DLY_CYC,
   parameter int BLINK_CYCLES = BLINK_CYC,
   parameter int SEC_CYCLES = SEC_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire cbc_cmp_t cmp_raw,
   input wire logic [2:0] src_code_in,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output cbc_ctl_t ana,
   output logic stat_o,
   output logic stat_oe_n,
   output logic int_pulse
);
   localparam logic [7:0] CLK_MASK = 8'h01 << CT_CLK;
   localparam logic [16:0] LIM_LOWV = 17'(TMR_LOWV_H * SEC_PER_H);
   localparam logic [16:0] LIM_0 = 17'(TMR_H0 * SEC_PER_H);
   localparam logic [16:0] LIM_1 = 17'(TMR_H1 * SEC_PER_H);
   localparam logic [16:0] LIM_2 = 17'(TMR_H2 * SEC_PER_H);
   localparam logic [16:0] LIM_3 = 17'(TMR_H3 * SEC_PER_H);

   cbc_cmp_t cmp;
   logic [$bits(cbc_cmp_t)-1:0] cmp_q;
   logic [7:0] ctrl_r, boost_r, sysmin_r, fast_charge_current_setting_r, ipt_r, vreg_r, tmr_r;
   logic [7:0] ctrl_nxt, rd_val, reg_rdata_r;
   logic wr_ctrl, wr_boost, wr_sysmin, wr_fast_charge_current_setting, wr_ipt, wr_vreg, wr_tmr;
   cbc_boost_state_t bstate_r, bstate_nxt;
   cbc_chg_state_t cstate_r, cstate_nxt, first_st;
   logic [25:0] dly_cnt_r, dly_cnt_nxt, pre_cnt_r, pre_cnt_nxt, blink_cnt_r;
   logic [16:0] sec_cnt_r, tmr_lim;
   logic chg_en, boost_req, boost_ok, boost_on, dly_done, rchg_ok, dynamic_power_mgmt, slow;
   logic charging, run_ok, start_ok, term_ok, tmr_exp, sec_tick, advance;
   logic half_ph_r, blink_r, bsw_r, bsw_nxt, int_pulse_r, stat_oe_n_r;
   logic [2:0] src_r;
   logic [1:0] phase_r, phase_nxt, fault_r;
   logic minsys_r, vdpm_r, idpm_r;
   cbc_ctl_t ana_r, ana_nxt;

   cbc_sync #(.W($bits(cbc_cmp_t))) u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .d(cmp_raw),
      .q(cmp_q)
   ); // RULE24
   assign cmp = cbc_cmp_t'(cmp_q);

   // Register decode
   assign wr_ctrl = reg_wr && (reg_addr == ADR_CTRL);
   assign wr_boost = reg_wr && (reg_addr == ADR_BOOST);
   assign wr_sysmin = reg_wr && (reg_addr == ADR_SYSMIN);
   assign wr_fast_charge_current_setting = reg_wr && (reg_addr == ADR_FAST_CHARGE_CURRENT_SETTING);
   assign wr_ipt = reg_wr && (reg_addr == ADR_IPT);
   assign wr_vreg = reg_wr && (reg_addr == ADR_VREG);
   assign wr_tmr = reg_wr && (reg_addr == ADR_TMR);
   // Clock select frozen during boost so the converter never changes frequency live
   assign ctrl_nxt = ctrl_r[CT_OTG] ? ((reg_wdata & ~CLK_MASK) | (ctrl_r & CLK_MASK))
                                    : reg_wdata; // RULE3

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_r <= RST_CTRL; // RULE13
         boost_r <= RST_BOOST; // RULE5
         sysmin_r <= RST_SYSMIN; // RULE7
         fast_charge_current_setting_r <= RST_FAST_CHARGE_CURRENT_SETTING;
         ipt_r <= RST_IPT;
         vreg_r <= RST_VREG;
         tmr_r <= RST_TMR;
      end else begin
         if (wr_ctrl) ctrl_r <= ctrl_nxt;
         if (wr_boost) boost_r <= reg_wdata;
         if (wr_sysmin) sysmin_r <= reg_wdata;
         if (wr_fast_charge_current_setting) fast_charge_current_setting_r <= reg_wdata;
         if (wr_ipt) ipt_r <= reg_wdata;
         if (wr_vreg) vreg_r <= reg_wdata;
         if (wr_tmr) tmr_r <= reg_wdata;
      end
   end

   always_comb begin
      unique case (reg_addr)
         ADR_CTRL: rd_val = ctrl_r;
         ADR_BOOST: rd_val = boost_r;
         ADR_SYSMIN: rd_val = sysmin_r;
         ADR_FAST_CHARGE_CURRENT_SETTING: rd_val = fast_charge_current_setting_r;
         ADR_IPT: rd_val = ipt_r;
         ADR_VREG: rd_val = vreg_r;
         ADR_TMR: rd_val = tmr_r;
         ADR_STAT0: rd_val = {src_r, phase_r, minsys_r, vdpm_r, idpm_r};
         ADR_STAT1: rd_val = {4'h0, bsw_r, boost_on, fault_r};
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) reg_rdata_r <= 8'h00;
      else reg_rdata_r <= reg_rd ? rd_val : 8'h00;
   end
   assign reg_rdata = reg_rdata_r;

   // Shared conditions
   assign chg_en = ctrl_r[CT_CHG] && !cmp.ce_n; // RULE12
   assign boost_req = ctrl_r[CT_OTG] && cmp.boost_pin;
   assign boost_ok = cmp.bat_lowv_ok && cmp.vbus_sleep && cmp.ts_boost_ok; // RULE1
   assign boost_on = (bstate_r == BS_ON);
   assign rchg_ok = ctrl_r[CT_RCHG] ? cmp.bat_rchg1_ok : cmp.bat_rchg0_ok;
   assign dynamic_power_mgmt = cmp.conv_on && (cmp.iin_over || cmp.vin_under); // RULE9
   assign slow = dynamic_power_mgmt || cmp.thermal_reg;
   assign charging = (cstate_r == CS_PRE) || (cstate_r == CS_FAST);
   assign run_ok = cmp.conv_on && chg_en && (fast_charge_current_setting_r[6:0] != 7'h00) && cmp.ts_chg_ok
                   && !ctrl_r[CT_SWOFF];
   assign start_ok = run_ok && (bstate_r == BS_OFF); // RULE14
   assign term_ok = cmp.fast_charge_current_setting_below_term && rchg_ok && !slow && ctrl_r[CT_TERM]; // RULE15 RULE22
   assign first_st = cmp.bat_3v_ok ? CS_FAST : CS_PRE; // RULE21

   // Boost sequencer
   assign dly_done = (dly_cnt_r == 26'(BOOST_DLY_CYCLES - 1));
   always_comb begin
      bstate_nxt = bstate_r;
      unique case (bstate_r)
         BS_OFF: if (boost_req && boost_ok) bstate_nxt = BS_WAIT; // RULE1
         BS_WAIT: begin
            if (!boost_req || !cmp.bat_lowv_ok) bstate_nxt = BS_OFF;
            else if (dly_done && boost_ok) bstate_nxt = BS_ON; // RULE1
         end
         BS_ON: if (!boost_req || !cmp.bat_otg_ok) bstate_nxt = BS_OFF; // RULE6
      endcase
   end
   assign dly_cnt_nxt = (bstate_r != BS_WAIT) ? 26'h0000000
                      : (dly_done ? dly_cnt_r : dly_cnt_r + 26'h0000001);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bstate_r <= BS_OFF;
         dly_cnt_r <= 26'h0000000;
      end else begin
         bstate_r <= bstate_nxt;
         dly_cnt_r <= dly_cnt_nxt;
      end
   end

   // Charge sequencer
   always_comb begin
      cstate_nxt = cstate_r;
      unique case (cstate_r)
         CS_IDLE: if (start_ok) cstate_nxt = first_st; // RULE14
         CS_PRE: begin
            if (!run_ok) cstate_nxt = CS_IDLE;
            else if (tmr_exp) cstate_nxt = CS_FAULT; // RULE23
            else if (cmp.bat_3v_ok) cstate_nxt = CS_FAST; // RULE21
         end
         CS_FAST: begin
            if (!run_ok) cstate_nxt = CS_IDLE;
            else if (tmr_exp) cstate_nxt = CS_FAULT; // RULE23
            else if (term_ok) cstate_nxt = CS_DONE; // RULE15
         end
         CS_DONE: begin
            if (!chg_en) cstate_nxt = CS_IDLE; // RULE17
            else if (!rchg_ok && start_ok) cstate_nxt = first_st; // RULE16
         end
         CS_FAULT: if (!chg_en) cstate_nxt = CS_IDLE;
      endcase
      // Boost owns the power stage
      if (bstate_r != BS_OFF) cstate_nxt = CS_IDLE; // RULE25
   end

   always_comb begin
      unique case (cstate_nxt)
         CS_PRE: phase_nxt = PH_PRE;
         CS_FAST: phase_nxt = PH_FAST;
         CS_DONE: phase_nxt = PH_DONE;
         default: phase_nxt = PH_OFF;
      endcase
   end // RULE19

   // Safety timer, seconds based; shorter limit while battery is very low
   assign tmr_lim = !cmp.bat_lowv_ok ? LIM_LOWV
                  : (tmr_r[TM_SEL_LSB +: 2] == 2'h0) ? LIM_0
                  : (tmr_r[TM_SEL_LSB +: 2] == 2'h1) ? LIM_1
                  : (tmr_r[TM_SEL_LSB +: 2] == 2'h2) ? LIM_2 : LIM_3;
   assign tmr_exp = tmr_r[TM_EN] && (sec_cnt_r >= tmr_lim);
   assign sec_tick = (pre_cnt_r == 26'(SEC_CYCLES - 1));
   assign pre_cnt_nxt = (!charging || sec_tick) ? 26'h0000000 : pre_cnt_r + 26'h0000001;
   assign advance = sec_tick && (!slow || !tmr_r[TM_HALF] || half_ph_r); // RULE22

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cstate_r <= CS_IDLE;
         pre_cnt_r <= 26'h0000000;
         sec_cnt_r <= 17'h00000;
         half_ph_r <= 1'b0;
      end else begin
         cstate_r <= cstate_nxt;
         pre_cnt_r <= pre_cnt_nxt;
         if (!charging) sec_cnt_r <= 17'h00000;
         else if (advance) sec_cnt_r <= sec_cnt_r + 17'h00001;
         if (sec_tick && slow) half_ph_r <= !half_ph_r;
      end
   end

   // Events and status
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         int_pulse_r <= 1'b0;
         fault_r <= 2'h0;
         phase_r <= PH_OFF;
      end else begin
         int_pulse_r <= ((cstate_nxt == CS_DONE) && (cstate_r != CS_DONE))
                        || ((cstate_nxt == CS_FAULT) && (cstate_r != CS_FAULT)); // RULE20 RULE23
         fault_r <= (cstate_nxt == CS_FAULT) ? FLT_TIMER : 2'h0; // RULE23
         phase_r <= phase_nxt;
      end
   end
   assign int_pulse = int_pulse_r;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         src_r <= 3'h0;
         minsys_r <= 1'b0;
         vdpm_r <= 1'b0;
         idpm_r <= 1'b0;
      end else begin
         src_r <= boost_on ? SRC_BOOST : src_code_in; // RULE4
         minsys_r <= cmp.bat_minsys_lo && cmp.conv_on; // RULE8
         vdpm_r <= cmp.conv_on && cmp.vin_under; // RULE10
         idpm_r <= cmp.conv_on && cmp.iin_over; // RULE10
      end
   end

   // Battery switch: on to charge, on to supplement, off at depletion
   assign bsw_nxt = ctrl_r[CT_SWOFF] ? 1'b0
                  : charging ? 1'b1
                  : !cmp.bat_depl_ok ? 1'b0
                  : cmp.sys_below_bat ? 1'b1 : bsw_r; // RULE11

   // Indicator blink only runs in fault, so it costs nothing otherwise
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bsw_r <= 1'b0;
         blink_cnt_r <= 26'h0000000;
         blink_r <= 1'b0;
         stat_oe_n_r <= 1'b1;
      end else begin
         bsw_r <= bsw_nxt;
         if (cstate_r != CS_FAULT || blink_cnt_r == 26'(BLINK_CYCLES - 1))
            blink_cnt_r <= 26'h0000000;
         else
            blink_cnt_r <= blink_cnt_r + 26'h0000001;
         if (cstate_r != CS_FAULT) blink_r <= 1'b0;
         else if (blink_cnt_r == 26'(BLINK_CYCLES - 1)) blink_r <= !blink_r;
         stat_oe_n_r <= ctrl_r[CT_IND_OFF]
                        || !(charging || (cstate_r == CS_FAULT && blink_r)); // RULE18
      end
   end
   assign stat_o = 1'b0;
   assign stat_oe_n = stat_oe_n_r;

   // Analog control word
   always_comb begin
      ana_nxt.boost_run = boost_on && cmp.ts_boost_ok; // RULE6
      ana_nxt.step_up_clock_sel = ctrl_r[CT_CLK]; // RULE3
      ana_nxt.step_up_current_limit = boost_r[BO_LIM_LSB +: 3]; // RULE2
      ana_nxt.boost_voltage_sel = boost_r[BO_VSEL_LSB +: 4]; // RULE5
      ana_nxt.min_system_voltage_sel = sysmin_r[2:0]; // RULE7
      ana_nxt.chg_run = charging;
      ana_nxt.cur_mode = !cmp.bat_2v_ok ? 2'h0 : (cstate_r == CS_FAST) ? 2'h2 : 2'h1; // RULE21
      ana_nxt.fast_charge_current_setting = fast_charge_current_setting_r[6:0];
      ana_nxt.pre_current = ipt_r[3:0];
      ana_nxt.charge_voltage = vreg_r[5:0];
      ana_nxt.temp_profile_en = tmr_r[TM_PROF];
      ana_nxt.chg_reduce = dynamic_power_mgmt; // RULE9
      ana_nxt.battery_switch = bsw_r;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) ana_r <= '0;
      else ana_r <= ana_nxt;
   end
   assign ana = ana_r;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_boost_src_code: assert property (boost_on |=> src_r == SRC_BOOST) // RULE4
      else $error("source code not 111 in boost");
   a_boost_excl_chg: assert property (bstate_r != BS_OFF |=> cstate_r == CS_IDLE) // RULE25
      else $error("charging while boost active");
   a_boost_entry_wait: assert property ($rose(boost_on) |-> $past(bstate_r) == BS_WAIT
      && $past(dly_cnt_r) == 26'(BOOST_DLY_CYCLES - 1) && $past(boost_ok)) // RULE1
      else $error("boost entered without delay or conditions");
   a_clk_sel_lock: assert property (wr_ctrl && ctrl_r[CT_OTG] |=> $stable(ctrl_r[CT_CLK])) // RULE3
      else $error("clock select changed during boost enable");
   a_term_held_off: assert property (cstate_r == CS_FAST && slow |=> cstate_r != CS_DONE) // RULE22
      else $error("terminated during regulation");
   a_done_irq_code: assert property ($rose(cstate_r == CS_DONE) |-> int_pulse_r
      && phase_r == PH_DONE) // RULE20
      else $error("done without interrupt or code");
   a_fault_code_set: assert property (cstate_r == CS_FAULT |-> fault_r == FLT_TIMER
      && !$past(cstate_r == CS_FAULT) == int_pulse_r) // RULE23
      else $error("timer fault code or interrupt wrong");
   a_phase_pre: assert property (cstate_r == CS_PRE |-> phase_r == PH_PRE) // RULE19
      else $error("precharge phase code wrong");
   a_switch_depl: assert property (!cmp.bat_depl_ok && !charging |=> !bsw_r) // RULE11
      else $error("battery switch on below depletion");
   a_ind_charging: assert property (charging && !ctrl_r[CT_IND_OFF] |=> !stat_oe_n) // RULE18
      else $error("indicator not low while charging");

   c_boost_on: cover property ($rose(boost_on));
   c_charge_done: cover property ($rose(cstate_r == CS_DONE));
   c_timer_fault: cover property ($rose(cstate_r == CS_FAULT));
   c_recharge: cover property (cstate_r == CS_DONE ##1 cstate_r == CS_FAST);
endmodule
`default_nettype wire

// >>> verification/cbc_ana_model.sv
`timescale 1ns/10ps
`default_nettype none
module cbc_ana_model
   import cbc_pkg::*;
#(
   parameter int LOWV_MV = 3000,
   parameter int OTG_MV = 2900,
   parameter int DEPL_MV = 2500,
   parameter int MINSYS_MV = 3500,
   parameter int RCHG0_MV = 4100,
   parameter int RCHG1_MV = 4000
) (
   input wire logic [15:0] bat_mv,
   input wire cbc_cmp_t pins,
   output cbc_cmp_t cmp
);
   // Cell level drives every battery comparator; other levels pass through
   always_comb begin
      cmp = pins;
      cmp.bat_lowv_ok = bat_mv > 16'(LOWV_MV);
      cmp.bat_2v_ok = bat_mv > 16'd2000;
      cmp.bat_3v_ok = bat_mv > 16'd3000;
      cmp.bat_minsys_lo = bat_mv < 16'(MINSYS_MV);
      cmp.bat_otg_ok = bat_mv > 16'(OTG_MV);
      cmp.bat_depl_ok = bat_mv > 16'(DEPL_MV);
      cmp.bat_rchg0_ok = bat_mv > 16'(RCHG0_MV);
      cmp.bat_rchg1_ok = bat_mv > 16'(RCHG1_MV);
   end
endmodule
`default_nettype wire

// >>> verification/charge_boost_control_fsm_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module charge_boost_control_fsm_tb_top
   import cbc_pkg::*;
;
   logic mclk, rst_n, reg_wr, reg_rd, stat_o, stat_oe_n, int_pulse;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [15:0] bat_mv;
   cbc_cmp_t pins, cmp;
   cbc_ctl_t ana;
   int checks, mismatches, ints, cyc;

   cbc_ana_model u_env (.bat_mv(bat_mv), .pins(pins), .cmp(cmp));
   cbc_ctrl_fsm #(.BOOST_DLY_CYCLES(20), .BLINK_CYCLES(8), .SEC_CYCLES(1)) u_dut (
      .mclk(mclk), .rst_n(rst_n), .cmp_raw(cmp), .src_code_in(3'h2),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ana(ana), .stat_o(stat_o), .stat_oe_n(stat_oe_n),
      .int_pulse(int_pulse));

   always #12.5 mclk = ~mclk;
   // Hang guard: safety timer wait dominates, about 18.5k cycles in all
   always @(posedge mclk) begin
      cyc++;
      if (int_pulse === 1'b1) ints++;
      if (cyc == 40000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] d;
      int n = 0;
      do begin
         rd(a, d);
         n++;
      end while (((d & m) !== e) && n < 80);
      chk(d & m, e);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic t_regs;
      logic [7:0] d;
      logic [7:0] rv [7] = '{RST_CTRL, RST_BOOST, RST_SYSMIN, RST_FAST_CHARGE_CURRENT_SETTING, RST_IPT, RST_VREG,
                             RST_TMR};
      for (int i = 0; i < 8; i++) begin
         rd(4'(i), d);
         chk(d, (i < 7) ? rv[i] : 8'h00);
      end
      chk({4'h0, ana.boost_voltage_sel}, {4'h0, RST_BOOST[BO_VSEL_LSB +: 4]});
      chk({5'h00, ana.min_system_voltage_sel}, {5'h00, RST_SYSMIN[2:0]});
      chk({2'h0, ana.charge_voltage}, {2'h0, RST_VREG[5:0]});
      for (int i = 0; i < 8; i++) begin
         wr(ADR_BOOST, {5'h07, 3'(i)});
         settle(2);
         chk({5'h00, ana.step_up_current_limit}, 8'(i));
      end
   endtask
   task automatic t_boost;
      logic [7:0] d;
      @(posedge mclk);
      pins.boost_pin <= 1'b1;
      pins.vbus_sleep <= 1'b1;
      pins.ts_boost_ok <= 1'b1;
      pins.ce_n <= 1'b0;
      pins.conv_on <= 1'b1;
      pins.ts_chg_ok <= 1'b1;
      bat_mv <= 16'd3800;
      wr(ADR_CTRL, 8'h43);
      wr(ADR_CTRL, 8'h47);
      rd(ADR_CTRL, d);
      chk(d, 8'h43);
      chk({7'h00, ana.boost_run}, 8'h00);
      poll(ADR_STAT1, 8'h04, 8'h04);
      poll(ADR_STAT0, 8'hE0, {SRC_BOOST, 5'h00});
      poll(ADR_STAT0, 8'h18, 8'h00);
      chk({7'h00, ana.chg_run}, 8'h00);
      bat_mv <= 16'd2800;
      settle(6);
      chk({7'h00, ana.boost_run}, 8'h00);
      wr(ADR_CTRL, 8'h41);
      wr(ADR_CTRL, 8'h45);
      settle(2);
      chk({7'h00, ana.step_up_clock_sel}, 8'h01);
      wr(ADR_CTRL, 8'h41);
   endtask
   task automatic t_charge;
      int n;
      poll(ADR_STAT0, 8'h18, {3'h0, PH_PRE, 3'h0});
      chk({6'h00, ana.cur_mode}, 8'h01);
      chk({7'h00, stat_oe_n}, 8'h00);
      bat_mv <= 16'd3700;
      poll(ADR_STAT0, 8'h18, {3'h0, PH_FAST, 3'h0});
      chk({6'h00, ana.cur_mode}, 8'h02);
      pins.iin_over <= 1'b1;
      poll(ADR_STAT0, 8'h01, 8'h01);
      chk({7'h00, ana.chg_reduce}, 8'h01);
      pins.vin_under <= 1'b1;
      poll(ADR_STAT0, 8'h02, 8'h02);
      bat_mv <= 16'd4200;
      pins.fast_charge_current_setting_below_term <= 1'b1;
      settle(8);
      poll(ADR_STAT0, 8'h18, {3'h0, PH_FAST, 3'h0});
      n = ints;
      pins.iin_over <= 1'b0;
      pins.vin_under <= 1'b0;
      poll(ADR_STAT0, 8'h18, {3'h0, PH_DONE, 3'h0});
      chk(8'(ints - n), 8'h01);
      chk({7'h00, stat_oe_n}, 8'h01);
      pins.fast_charge_current_setting_below_term <= 1'b0;
      bat_mv <= 16'd3900;
      poll(ADR_STAT0, 8'h18, {3'h0, PH_FAST, 3'h0});
      bat_mv <= 16'd4200;
      pins.fast_charge_current_setting_below_term <= 1'b1;
      poll(ADR_STAT0, 8'h18, {3'h0, PH_DONE, 3'h0});
      pins.fast_charge_current_setting_below_term <= 1'b0;
      wr(ADR_CTRL, 8'h40);
      wr(ADR_CTRL, 8'h41);
      poll(ADR_STAT0, 8'h18, {3'h0, PH_FAST, 3'h0});
      wr(ADR_CTRL, 8'h49);
      settle(4);
      chk({7'h00, stat_oe_n}, 8'h01);
      wr(ADR_FAST_CHARGE_CURRENT_SETTING, 8'h00);
      wr(ADR_CTRL, 8'h40);
      wr(ADR_CTRL, 8'h41);
      settle(8);
      poll(ADR_STAT0, 8'h18, {3'h0, PH_OFF, 3'h0});
      wr(ADR_FAST_CHARGE_CURRENT_SETTING, RST_FAST_CHARGE_CURRENT_SETTING);
   endtask
   task automatic t_path;
      bat_mv <= 16'd3300;
      poll(ADR_STAT0, 8'h04, 8'h04);
      // Charging keeps the switch on, so stop it and clear the switch first
      wr(ADR_CTRL, 8'h20);
      poll(ADR_STAT1, 8'h08, 8'h00);
      wr(ADR_CTRL, 8'h00);
      pins.sys_below_bat <= 1'b1;
      poll(ADR_STAT1, 8'h08, 8'h08);
      bat_mv <= 16'd2400;
      poll(ADR_STAT1, 8'h08, 8'h00);
   endtask
   task automatic t_fault;
      logic [7:0] d;
      int n;
      bat_mv <= 16'd3800;
      pins.sys_below_bat <= 1'b0;
      wr(ADR_TMR, 8'h0C);
      n = ints;
      wr(ADR_CTRL, 8'h41);
      poll(ADR_STAT0, 8'h18, {3'h0, PH_FAST, 3'h0});
      // Shortest selectable limit, 5 h, one timer second per cycle
      settle(TMR_H0 * SEC_PER_H + 10);
      poll(ADR_STAT1, 8'h03, {6'h00, FLT_TIMER});
      chk(8'(ints - n), 8'h01);
      d = {7'h00, stat_oe_n};
      settle(8);
      chk({7'h00, stat_oe_n} ^ d, 8'h01);
      chk({7'h00, stat_o}, 8'h00);
      wr(ADR_CTRL, 8'h40);
      poll(ADR_STAT1, 8'h03, 8'h00);
   endtask

   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      bat_mv = 16'd3800;
      pins = '0;
      pins.ce_n = 1'b1;
      checks = 0;
      mismatches = 0;
      ints = 0;
      cyc = 0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_boost();
      t_charge();
      t_path();
      t_fault();
      final_report();
   end
endmodule
`default_nettype wire
